// file: scd_pkg.sv
package scd_pkg;
  localparam int          NUM_CH        = 4;
  localparam int          NUM_STRAP     = 6;
  localparam int          CODE_W        = 3;
  localparam int          RATIO_W       = 5;
  localparam int          PHASE_W       = 10;
  localparam int          PAIR_A_IDX    = 4;
  localparam int          PAIR_B_IDX    = 5;
  localparam logic [4:0]  RATIO_RST     = 5'h01;
  localparam logic [9:0]  PHASE_RST     = 10'h000;
  // Cycles after reset release before the straps are captured
  // A plain count: a real-to-int cast rounds, which would give one cycle more
  localparam int          SETTLE_CYC    = 4;
  localparam logic [3:0]  SETTLE_RST    = 4'h0;

  typedef enum logic [1:0] {SCD_DRV_HSTL, SCD_DRV_LVDS, SCD_DRV_OFF} scd_drv_t;
  typedef enum logic [1:0] {SCD_SEL_NONE, SCD_SEL_SPI, SCD_SEL_I2C, SCD_SEL_STRAP} scd_sel_t;
  typedef enum logic [1:0] {SCD_MODE_SPI, SCD_MODE_I2C, SCD_MODE_STRAP} scd_mode_t;

  typedef struct packed {
    logic [RATIO_W-1:0] ratio;
    logic [PHASE_W-1:0] phase;
    scd_drv_t           drv;
  } scd_chan_t;

  typedef struct packed {
    logic [RATIO_W-1:0] ratio;
    logic [PHASE_W-1:0] phase;
    scd_drv_t           drv;
  } scd_serial_t;
endpackage

// file: scd_pair_decode.sv
`timescale 1ns/1ps
module scd_pair_decode
  import scd_pkg::*;
(
  // Strap code
  input  wire logic [scd_pkg::CODE_W-1:0] code,
  // Driver types of the pair
  output scd_pkg::scd_drv_t               drv_lo,
  output scd_pkg::scd_drv_t               drv_hi
);
  import scd_pkg::*;

  always_comb
  begin
    drv_lo = SCD_DRV_OFF;
    drv_hi = SCD_DRV_OFF;
    unique case (code)
      3'h0:
      begin
        drv_lo = SCD_DRV_HSTL;
        drv_hi = SCD_DRV_HSTL;
      end
      3'h1:
      begin
        drv_lo = SCD_DRV_HSTL;
        drv_hi = SCD_DRV_LVDS;
      end
      3'h2:
      begin
        drv_lo = SCD_DRV_HSTL;
        drv_hi = SCD_DRV_OFF;
      end
      3'h3:
      begin
        drv_lo = SCD_DRV_LVDS;
        drv_hi = SCD_DRV_HSTL;
      end
      3'h4:
      begin
        drv_lo = SCD_DRV_LVDS;
        drv_hi = SCD_DRV_LVDS;
      end
      3'h5:
      begin
        drv_lo = SCD_DRV_LVDS;
        drv_hi = SCD_DRV_OFF;
      end
      3'h6:
      begin
        drv_lo = SCD_DRV_OFF;
        drv_hi = SCD_DRV_HSTL;
      end
      3'h7:
      begin
        drv_lo = SCD_DRV_OFF;
        drv_hi = SCD_DRV_OFF;
      end
    endcase
  end
endmodule

// file: scd_top.sv
// Notes on behaviour
// - Four outputs from one reference, each with its own divider setting.
// - Method is serial (SPI or I2C) or straps; no selection means SPI.
// - Serial mode uses straps 0-2 as clock, data in, select; data out comes from the serial engine.
// - Each strap resolves to a 3-bit code: 0-3 to ground, 4-7 to supply.
// - Straps 0-3 set only their channel ratio: 1,2,3,4,5,6,8,16.
// - Strap 4 sets channels 0/1 driver types, strap 5 channels 2/3.
// - Strap mode limits ratios to the table and forces zero phase.
`timescale 1ns/1ps
module scd_top
  import scd_pkg::*;
(
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          nrst,
  // Method selection pin and resolved strap codes
  input  wire scd_pkg::scd_sel_t             method_sel,
  input  wire logic [scd_pkg::CODE_W-1:0]    strap_pin [scd_pkg::NUM_STRAP],
  // Settings from the serial register block
  input  wire scd_pkg::scd_serial_t          serial_cfg [scd_pkg::NUM_CH],
  // Serial data out drive from the serial engine
  input  wire logic                          serial_data_out_d,
  input  wire logic                          serial_data_out_en,
  // Per-channel settings to dividers and drivers
  output scd_pkg::scd_chan_t                 chan_cfg_r [scd_pkg::NUM_CH],
  output scd_pkg::scd_mode_t                 mode_r,
  output logic                               cfg_valid_r,
  // Serial bus lines: clock, data in, select from straps 0-2; data out from the serial engine
  output logic                               serial_clk_r,
  output logic                               serial_data_in_r,
  output logic                               serial_cs_n_r,
  output logic                               serial_data_out_r,
  output logic                               serial_data_out_oe_r
);
  import scd_pkg::*;

  default clocking cb_sys @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  // Two-flop synchronisers on the strap and selection pins
  logic [CODE_W-1:0] strap_s1_r [NUM_STRAP];
  logic [CODE_W-1:0] strap_s2_r [NUM_STRAP];
  scd_sel_t          sel_s1_r;
  scd_sel_t          sel_s2_r;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < NUM_STRAP; i++)
      begin
        strap_s1_r[i] <= 3'h0;
        strap_s2_r[i] <= 3'h0;
      end
      sel_s1_r <= SCD_SEL_NONE;
      sel_s2_r <= SCD_SEL_NONE;
    end
    else
    begin
      for (int i = 0; i < NUM_STRAP; i++)
      begin
        strap_s1_r[i] <= strap_pin[i];
        strap_s2_r[i] <= strap_s1_r[i];
      end
      sel_s1_r <= method_sel;
      sel_s2_r <= sel_s1_r;
    end
  end

  // Settle counter; capture once, then hold until next reset
  logic [3:0] settle_r;
  logic [3:0] settle_nxt;
  logic       cap_nxt;
  scd_mode_t  mode_nxt;

  always_comb
  begin
    settle_nxt = settle_r;
    cap_nxt    = cfg_valid_r;
    mode_nxt   = mode_r;
    if (!cfg_valid_r)
    begin
      if (settle_r == 4'(SETTLE_CYC))
      begin
        cap_nxt = 1'b1;
        unique case (sel_s2_r)
          SCD_SEL_STRAP: mode_nxt = SCD_MODE_STRAP;
          SCD_SEL_I2C:   mode_nxt = SCD_MODE_I2C;
          default:       mode_nxt = SCD_MODE_SPI;
        endcase
      end
      else
        settle_nxt = settle_r + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      settle_r    <= SETTLE_RST;
      cfg_valid_r <= 1'b0;
      mode_r      <= SCD_MODE_SPI;
    end
    else
    begin
      settle_r    <= settle_nxt;
      cfg_valid_r <= cap_nxt;
      mode_r      <= mode_nxt;
    end
  end

  // Latched strap codes
  logic [CODE_W-1:0] code_r   [NUM_STRAP];
  logic [CODE_W-1:0] code_nxt [NUM_STRAP];

  always_comb
  begin
    for (int i = 0; i < NUM_STRAP; i++)
      code_nxt[i] = (!cfg_valid_r && cap_nxt) ? strap_s2_r[i] : code_r[i];
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      for (int i = 0; i < NUM_STRAP; i++)
        code_r[i] <= 3'h0;
    else
      for (int i = 0; i < NUM_STRAP; i++)
        code_r[i] <= code_nxt[i];
  end

  function automatic logic [RATIO_W-1:0] ratio_of(input logic [CODE_W-1:0] c);
    logic [RATIO_W-1:0] r;
    r = 5'h01;
    unique case (c)
      3'h0: r = 5'h01;
      3'h1: r = 5'h02;
      3'h2: r = 5'h03;
      3'h3: r = 5'h04;
      3'h4: r = 5'h05;
      3'h5: r = 5'h06;
      3'h6: r = 5'h08;
      3'h7: r = 5'h10;
    endcase
    return r;
  endfunction

  scd_drv_t strap_drv [NUM_CH];

  // Pair pins sit next to each other: first pair for channels 0/1, second for 2/3
  for (genvar p = 0; p < 2; p++)
  begin : g_pair
    scd_pair_decode scd_pair_decode_inst (
      .code   (code_r[PAIR_A_IDX + p]),
      .drv_lo (strap_drv[2 * p]),
      .drv_hi (strap_drv[2 * p + 1])
    );
  end

  // Channel settings; serial mode follows the register block live
  scd_chan_t chan_nxt [NUM_CH];

  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      chan_nxt[i] = chan_cfg_r[i];
      if (cfg_valid_r)
      begin
        if (mode_r == SCD_MODE_STRAP)
        begin
          chan_nxt[i].ratio = ratio_of(code_r[i]);
          chan_nxt[i].phase = PHASE_RST;
          chan_nxt[i].drv   = strap_drv[i];
        end
        else
          chan_nxt[i] = serial_cfg[i];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      for (int i = 0; i < NUM_CH; i++)
        chan_cfg_r[i] <= '{ratio: RATIO_RST, phase: PHASE_RST, drv: SCD_DRV_OFF};
    else
      for (int i = 0; i < NUM_CH; i++)
        chan_cfg_r[i] <= chan_nxt[i];
  end

  // Serial line routing; idle values outside serial mode
  logic serial_on;
  assign serial_on = cfg_valid_r && (mode_r != SCD_MODE_STRAP);

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      serial_clk_r         <= 1'b0;
      serial_data_in_r     <= 1'b0;
      serial_cs_n_r        <= 1'b1;
      serial_data_out_r    <= 1'b0;
      serial_data_out_oe_r <= 1'b0;
    end
    else
    begin
      serial_clk_r         <= serial_on ? strap_s2_r[0][0] : 1'b0;
      serial_data_in_r     <= serial_on ? strap_s2_r[1][0] : 1'b0;
      serial_cs_n_r        <= serial_on ? strap_s2_r[2][0] : 1'b1;
      serial_data_out_r    <= serial_on & serial_data_out_d;
      serial_data_out_oe_r <= serial_on & serial_data_out_en;
    end
  end

  property p_strap_phase;
    (cfg_valid_r && mode_r == SCD_MODE_STRAP) |=> chan_cfg_r[0].phase == PHASE_RST;
  endproperty
  a_strap_phase: assert property (p_strap_phase)
    else $error("phase not zero in strap mode");
  property p_strap_ratio;
    (cfg_valid_r && mode_r == SCD_MODE_STRAP && code_r[0] == 3'h7)
      |=> chan_cfg_r[0].ratio == 5'h10;
  endproperty
  a_strap_ratio: assert property (p_strap_ratio)
    else $error("ratio code 7 not divide by 16");
  property p_hold;
    cfg_valid_r |=> cfg_valid_r && $stable(mode_r) && $stable(code_r[4]);
  endproperty
  a_hold: assert property (p_hold)
    else $error("captured settings changed");
  // Bound covers two sync stages, the settle count and the capture edge
  property p_capture_time;
    !cfg_valid_r |-> ##[1:8] cfg_valid_r;
  endproperty
  a_capture_time: assert property (p_capture_time)
    else $error("capture late");
  property p_default_spi;
    (!cfg_valid_r && cap_nxt && sel_s2_r == SCD_SEL_NONE) |=> mode_r == SCD_MODE_SPI;
  endproperty
  a_default_spi: assert property (p_default_spi)
    else $error("no selection did not give SPI");
  property p_pair;
    (cfg_valid_r && mode_r == SCD_MODE_STRAP && code_r[4] == 3'h5)
      |=> chan_cfg_r[0].drv == SCD_DRV_LVDS && chan_cfg_r[1].drv == SCD_DRV_OFF;
  endproperty
  a_pair: assert property (p_pair)
    else $error("pair code 5 wrong");
  property p_sdo_off;
    (mode_r == SCD_MODE_STRAP) |=> !serial_data_out_oe_r;
  endproperty
  a_sdo_off: assert property (p_sdo_off)
    else $error("data out driven in strap mode");
  property p_serial_follow;
    (cfg_valid_r && mode_r != SCD_MODE_STRAP) |=> chan_cfg_r[2] == $past(serial_cfg[2]);
  endproperty
  a_serial_follow: assert property (p_serial_follow)
    else $error("serial settings not followed");
  c_strap: cover property (@(posedge sys_clk) cfg_valid_r && mode_r == SCD_MODE_STRAP);
  c_spi: cover property (@(posedge sys_clk) cfg_valid_r && mode_r == SCD_MODE_SPI);
  c_i2c: cover property (@(posedge sys_clk) cfg_valid_r && mode_r == SCD_MODE_I2C);
endmodule

// file: scd_strap_model.sv
`timescale 1ns/1ps
module scd_strap_model
  import scd_pkg::*;
(
  // Straps and selection pin
  output scd_pkg::scd_sel_t          method_sel,
  output logic [scd_pkg::CODE_W-1:0] strap_pin [scd_pkg::NUM_STRAP],
  // Serial register block
  output scd_pkg::scd_serial_t       serial_cfg [scd_pkg::NUM_CH]
);
  import scd_pkg::*;

  // Straps are set by the board; the bench moves them at each restart, for hold checks and for serial routing checks
  task automatic set_pins(input scd_sel_t sel, input logic [17:0] codes);
    method_sel = sel;
    for (int i = 0; i < NUM_STRAP; i++)
      strap_pin[i] = codes[3*i +: 3];
  endtask

  task automatic set_serial(input int base);
    for (int i = 0; i < NUM_CH; i++)
      serial_cfg[i] = '{ratio: 5'(base + i), phase: 10'(base * 7 + i + 1),
                        drv: scd_drv_t'(2'((base + i) % 3))};
  endtask

  initial
  begin
    set_pins(SCD_SEL_NONE, 18'h00000);
    set_serial(3);
  end
endmodule

// file: strap_config_decoder_tb.sv
`timescale 1ns/1ps
module strap_config_decoder_tb;
  import scd_pkg::*;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        sdo_d = 1'b0;
  logic        sdo_en = 1'b0;
  scd_sel_t    method_sel;
  logic [2:0]  strap_pin [NUM_STRAP];
  scd_serial_t serial_cfg [NUM_CH];
  scd_chan_t   chan_cfg_r [NUM_CH];
  scd_mode_t   mode_r;
  logic        cfg_valid_r, s_clk, s_din, s_cs_n, s_dout, s_oe;
  int          mismatches = 0;
  int          n_compared = 0;

  always #2.5 sys_clk = ~sys_clk;

  scd_strap_model scd_strap_model_inst (.method_sel(method_sel), .strap_pin(strap_pin),
    .serial_cfg(serial_cfg));
  scd_top scd_top_inst (.sys_clk(sys_clk), .nrst(nrst), .method_sel(method_sel),
    .strap_pin(strap_pin), .serial_cfg(serial_cfg), .serial_data_out_d(sdo_d),
    .serial_data_out_en(sdo_en), .chan_cfg_r(chan_cfg_r), .mode_r(mode_r),
    .cfg_valid_r(cfg_valid_r), .serial_clk_r(s_clk), .serial_data_in_r(s_din),
    .serial_cs_n_r(s_cs_n), .serial_data_out_r(s_dout), .serial_data_out_oe_r(s_oe));

  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  function automatic logic [4:0] exp_ratio(input logic [2:0] c);
    case (c)
      3'h6: return 5'h08;
      3'h7: return 5'h10;
      default: return 5'(c) + 5'h01;
    endcase
  endfunction

  function automatic logic [1:0] exp_drv(input logic [2:0] c, input bit second);
    if (!second)
      return 2'(c / 3);
    return (c == 3'h7) ? 2'(SCD_DRV_OFF) : 2'(c % 3);
  endfunction

  // Reset values are checked each time, then the capture is awaited
  task automatic restart(input scd_sel_t sel, input logic [17:0] codes);
    int n;
    @(negedge sys_clk);
    nrst = 1'b0;
    scd_strap_model_inst.set_pins(sel, codes);
    repeat (20) @(negedge sys_clk);
    for (int i = 0; i < NUM_CH; i++)
      check(chan_cfg_r[i], {RATIO_RST, PHASE_RST, SCD_DRV_OFF});
    check({mode_r, cfg_valid_r, s_clk, s_din, s_cs_n, s_dout, s_oe}, {SCD_MODE_SPI, 6'h04});
    nrst = 1'b1;
    n = 0;
    while (cfg_valid_r !== 1'b1 && n < 50)
    begin
      @(negedge sys_clk);
      n++;
    end
    check(cfg_valid_r, 1'b1);
    repeat (2) @(negedge sys_clk);
  endtask

  task automatic test_strap;
    logic [17:0] codes;
    for (int k = 0; k < 8; k++)
    begin
      for (int i = 0; i < NUM_STRAP; i++)
        codes[3*i +: 3] = 3'((k + i) % 8);
      restart(SCD_SEL_STRAP, codes);
      check(mode_r, SCD_MODE_STRAP);
      check(s_oe, 1'b0);
      check({s_clk, s_din, s_cs_n}, 3'h1);
      for (int c = 0; c < NUM_CH; c++)
      begin
        check(chan_cfg_r[c].ratio, exp_ratio(codes[3*c +: 3]));
        check(chan_cfg_r[c].phase, PHASE_RST);
        check(chan_cfg_r[c].drv, exp_drv(codes[3*(4 + c/2) +: 3], c[0]));
      end
      // Late pin and serial changes must not disturb the captured setup
      scd_strap_model_inst.set_pins(SCD_SEL_SPI, ~codes);
      scd_strap_model_inst.set_serial(k + 11);
      sdo_d = 1'b1;
      sdo_en = 1'b1;
      repeat (8) @(negedge sys_clk);
      check({s_dout, s_oe}, 2'h0);
      check(mode_r, SCD_MODE_STRAP);
      check(chan_cfg_r[0].ratio, exp_ratio(codes[2:0]));
      check(chan_cfg_r[3].phase, PHASE_RST);
    end
  endtask

  task automatic test_serial;
    scd_sel_t  sels [3] = '{SCD_SEL_NONE, SCD_SEL_SPI, SCD_SEL_I2C};
    scd_mode_t modes [3] = '{SCD_MODE_SPI, SCD_MODE_SPI, SCD_MODE_I2C};
    for (int s = 0; s < 3; s++)
    begin
      sdo_en = 1'b0;
      restart(sels[s], 18'h001D5);
      check(mode_r, modes[s]);
      check({s_clk, s_din, s_cs_n}, 3'h5);
      scd_strap_model_inst.set_serial(s + 20);
      sdo_d = 1'b1;
      sdo_en = 1'b1;
      scd_strap_model_inst.set_pins(sels[s], 18'h0019C);
      repeat (4) @(negedge sys_clk);
      for (int c = 0; c < NUM_CH; c++)
        check(chan_cfg_r[c], serial_cfg[c]);
      check({s_clk, s_din, s_cs_n}, 3'h2);
      check({s_dout, s_oe}, 2'h3);
      sdo_en = 1'b0;
      repeat (4) @(negedge sys_clk);
      check(s_oe, 1'b0);
    end
  endtask

  initial
  begin
    #100000;
    mismatches++;
    $display("Error at %0t: watchdog expired", $time);
    finish_test();
  end

  initial
  begin
    test_strap();
    test_serial();
    finish_test();
  end
endmodule
